// >>> core/sipp_top.sv
`timescale 1ns/1ps
`default_nettype none
module sipp_top
	import sipp_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                reset,
	input  wire logic                clk_en,
	input  wire logic                req_valid,
	input  wire logic [6:0]          req_cfg_num,
	input  wire logic                req_write,
	input  wire logic                wbuf_wr_en,
	input  wire logic [3:0]          wbuf_addr,
	input  wire logic [7:0]          wbuf_data,
	input  wire logic [3:0]          rbuf_addr,
	input  wire logic                sensor_present,
	input  wire logic [7:0]          sensor_driver_tag,
	input  wire logic [7:0]          drv_revision,
	input  wire logic [7:0]          supply_current,
	input  wire logic [15:0]         dyn_range,
	input  wire logic                irq_enabled,
	input  wire sipp_pwr_type        pwr_mode,
	input  wire logic [15:0]         sample_rate,
	input  wire logic [7:0]          axis_count,
	input  wire logic [35:0]         coef_flat,
	input  wire logic [7:0]          conf_rd_data,
	input  wire logic signed [15:0]  raw_x,
	input  wire logic signed [15:0]  raw_y,
	input  wire logic signed [15:0]  raw_z,
	input  wire logic                raw_valid,
	output var  logic                req_busy,
	output var  logic                req_done,
	output var  logic                req_refused,
	output var  logic [4:0]          sel_sensor_id,
	output var  logic                sel_wakeup,
	output var  logic                sel_config,
	output var  logic [3:0]          conf_addr,
	output var  logic                conf_wr_en,
	output var  logic [7:0]          conf_wr_data,
	output var  logic [7:0]          rbuf_data,
	output var  logic signed [21:0]  east_north_up_frame_x,
	output var  logic signed [21:0]  east_north_up_frame_y,
	output var  logic signed [21:0]  east_north_up_frame_z,
	output var  logic                aligned_valid
);
	typedef struct packed {
		sipp_state_type    st;
		logic [3:0]        idx;
		logic [6:0]        num;
		logic              wr;
		logic              busy;
		logic              done;
		logic              refused;
		logic [4:0]        id;
		logic              wake;
		logic              conf;
		logic [3:0]        caddr;
		logic              cwr;
		logic [7:0]        cdata;
		logic signed [21:0] ax;
		logic signed [21:0] ay;
		logic signed [21:0] az;
		logic              avld;
	} sipp_state_regs_type;

	sipp_state_regs_type s_q;
	sipp_state_regs_type s_d;

	logic [7:0] rmem_wdata;
	logic       rmem_we;
	logic [7:0] wmem_rdata;
	logic [7:0] rmem_rdata;

	function automatic logic signed [21:0] coef_mul(
		input logic [3:0]         c,
		input logic signed [15:0] v
	);
		logic signed [4:0] cs;
		cs = 5'(signed'(c));
		return 22'(v * cs);
	endfunction : coef_mul

	function automatic logic [3:0] coef_at(
		input logic [35:0] flat,
		input int          k
	);
		return flat[k*4 +: 4];
	endfunction : coef_at

	function automatic logic [7:0] rec_byte(
		input logic [3:0] i,
		input logic [6:0] n,
		input logic       present
	);
		logic [7:0] b;
		b = BYTE_ZERO;
		if (!present) begin
			b = BYTE_ZERO;
		end else if (i == 4'(BYTE_TYPE)) begin
			b = 8'({1'b0, n}) - TYPE_OFFSET;
		end else if (i == 4'(BYTE_DRV_TAG)) begin
			b = sensor_driver_tag;
		end else if (i == 4'(BYTE_DRV_REV)) begin
			b = drv_revision;
		end else if (i == 4'(BYTE_CURRENT)) begin
			b = supply_current;
		end else if (i == 4'(BYTE_RANGE_LO)) begin
			b = dyn_range[7:0];
		end else if (i == 4'(BYTE_RANGE_HI)) begin
			b = dyn_range[15:8];
		end else if (i == 4'(BYTE_FLAGS)) begin
			b = BYTE_ZERO;
			b[FLAG_IRQ_BIT] = irq_enabled;
			b[FLAG_PWR_LSB +: 3] = pwr_mode;
		end else if (i == 4'(BYTE_RSVD)) begin
			b = BYTE_ZERO;
		end else if (i == 4'(BYTE_RATE_LO)) begin
			b = sample_rate[7:0];
		end else if (i == 4'(BYTE_RATE_HI)) begin
			b = sample_rate[15:8];
		end else if (i == 4'(BYTE_AXES)) begin
			b = axis_count;
		end else if (i == 4'(BYTE_MATRIX) + 4'h4) begin
			// ninth coefficient alone, high nibble zero
			b = {4'h0, coef_at(coef_flat, 8)};
		end else begin
			b = coef_flat[(int'(i) - BYTE_MATRIX) * 8 +: 8];
		end
		return b;
	endfunction : rec_byte

	sipp_byte_mem u_rbuf (
		.sys_clk (sys_clk),
		.clk_en  (clk_en),
		.wr_en   (rmem_we),
		.wr_addr (s_q.idx),
		.wr_data (rmem_wdata),
		.rd_addr (rbuf_addr),
		.rd_data (rmem_rdata)
	);

	sipp_byte_mem u_wbuf (
		.sys_clk (sys_clk),
		.clk_en  (clk_en),
		.wr_en   (wbuf_wr_en),
		.wr_addr (wbuf_addr),
		.wr_data (wbuf_data),
		.rd_addr (s_d.idx),
		.rd_data (wmem_rdata)
	);

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.refused = 1'b0;
		s_d.cwr = 1'b0;
		s_d.avld = 1'b0;
		rmem_we = 1'b0;
		rmem_wdata = BYTE_ZERO;
		// aligned = raw row times matrix, row-major coefficients
		if (raw_valid) begin
			s_d.ax = coef_mul(coef_at(coef_flat, 0), raw_x)
				+ coef_mul(coef_at(coef_flat, 3), raw_y)
				+ coef_mul(coef_at(coef_flat, 6), raw_z);
			s_d.ay = coef_mul(coef_at(coef_flat, 1), raw_x)
				+ coef_mul(coef_at(coef_flat, 4), raw_y)
				+ coef_mul(coef_at(coef_flat, 7), raw_z);
			s_d.az = coef_mul(coef_at(coef_flat, 2), raw_x)
				+ coef_mul(coef_at(coef_flat, 5), raw_y)
				+ coef_mul(coef_at(coef_flat, 8), raw_z);
			s_d.avld = 1'b1;
		end
		case (s_q.st)
			ST_IDLE: begin
				s_d.idx = ADDR_ZERO;
				// config reads start at entry 0
				s_d.caddr = ADDR_ZERO;
				if (req_valid) begin
					s_d.num = req_cfg_num;
					s_d.id = req_cfg_num[CFG_ID_MSB:0];
					s_d.wake = req_cfg_num[CFG_WAKE_BIT];
					s_d.conf = req_cfg_num[CFG_CONF_BIT];
					s_d.wr = req_write;
					// id zero is reserved in every range
					if (req_cfg_num[CFG_ID_MSB:0] == ID_ZERO
						|| (req_write && !req_cfg_num[CFG_CONF_BIT])) begin
						s_d.refused = 1'b1;
						s_d.done = 1'b1;
					end else begin
						s_d.busy = 1'b1;
						s_d.st = ST_FILL;
					end
				end
			end
			ST_FILL: begin
				if (s_q.conf && s_q.wr) begin
					s_d.caddr = s_q.idx;
					s_d.cwr = 1'b1;
					s_d.cdata = wmem_rdata;
				end else if (s_q.conf) begin
					// configuration read into buffer
					// address register tracks idx so byte i is entry i
					s_d.caddr = s_q.idx + 4'h1;
					rmem_we = 1'b1;
					rmem_wdata = conf_rd_data;
				end else begin
					rmem_we = 1'b1;
					rmem_wdata = rec_byte(s_q.idx, s_q.num, sensor_present);
				end
				s_d.idx = s_q.idx + 4'h1;
				if (s_q.idx == 4'(REC_BYTES - 1)) begin
					s_d.st = ST_DONE;
				end
			end
			ST_DONE: begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				s_d.st = ST_IDLE;
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s_q <= '0;
			rbuf_data <= BYTE_ZERO;
		end else if (clk_en) begin
			s_q <= s_d;
			rbuf_data <= rmem_rdata;
		end
	end

	assign req_busy = s_q.busy;
	assign req_done = s_q.done;
	assign req_refused = s_q.refused;
	assign sel_sensor_id = s_q.id;
	assign sel_wakeup = s_q.wake;
	assign sel_config = s_q.conf;
	assign conf_addr = s_q.caddr;
	assign conf_wr_en = s_q.cwr;
	assign conf_wr_data = s_q.cdata;
	assign east_north_up_frame_x = s_q.ax;
	assign east_north_up_frame_y = s_q.ay;
	assign east_north_up_frame_z = s_q.az;
	assign aligned_valid = s_q.avld;
endmodule : sipp_top
`default_nettype wire

// >>> core/sipp_pkg.sv
// shared constants and types for the sensor information parameter page
package sipp_pkg;
	localparam int REC_BYTES        = 16;
	localparam int BYTE_TYPE        = 0;
	localparam int BYTE_DRV_TAG     = 1;
	localparam int BYTE_DRV_REV     = 2;
	localparam int BYTE_CURRENT     = 3;
	localparam int BYTE_RANGE_LO    = 4;
	localparam int BYTE_RANGE_HI    = 5;
	localparam int BYTE_FLAGS       = 6;
	localparam int BYTE_RSVD        = 7;
	localparam int BYTE_RATE_LO     = 8;
	localparam int BYTE_RATE_HI     = 9;
	localparam int BYTE_AXES        = 10;
	localparam int BYTE_MATRIX      = 11;
	localparam int FLAG_IRQ_BIT     = 0;
	localparam int FLAG_PWR_LSB     = 5;
	localparam int CFG_ID_MSB       = 4;
	localparam int CFG_WAKE_BIT     = 5;
	localparam int CFG_CONF_BIT     = 6;
	localparam logic [7:0] TYPE_OFFSET = 8'h20;
	localparam logic [7:0] BYTE_ZERO   = 8'h00;
	localparam logic [3:0] ADDR_ZERO   = 4'h0;
	localparam logic [4:0] ID_ZERO     = 5'h00;

	typedef enum logic [2:0] {
		PWR_ABSENT, PWR_DOWN, PWR_SUSPEND, PWR_SELFTEST,
		PWR_MOTION_IRQ, PWR_ONE_SHOT, PWR_LOW_ACTIVE, PWR_ACTIVE
	} sipp_pwr_type;

	typedef enum logic [1:0] {
		SEL_INFO_NONWAKE, SEL_INFO_WAKE, SEL_CONF_NONWAKE, SEL_CONF_WAKE
	} sipp_sel_type;

	typedef enum logic [1:0] {
		ST_IDLE, ST_FILL, ST_DONE
	} sipp_state_type;
endpackage : sipp_pkg

// >>> core/sipp_byte_mem.sv
// small byte memory used for the read and write staging buffers
`timescale 1ns/1ps
`default_nettype none
module sipp_byte_mem
	import sipp_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       clk_en,
	input  wire logic       wr_en,
	input  wire logic [3:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [3:0] rd_addr,
	output var  logic [7:0] rd_data
);
	logic [7:0] mem [REC_BYTES];

	// no reset: contents are always rewritten before use
	always_ff @(posedge sys_clk) begin
		if (clk_en) begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule : sipp_byte_mem
`default_nettype wire

// >>> dv/sipp_conf_store.sv
// config store model on the far side of the configuration port
`timescale 1ns/1ps
`default_nettype none
module sipp_conf_store (
	input  wire logic       sys_clk,
	input  wire logic [3:0] conf_addr,
	input  wire logic       conf_wr_en,
	input  wire logic [7:0] conf_wr_data,
	output var  logic [7:0] conf_rd_data
);
	logic [7:0] mem [16] = '{default: 8'h00};
	always @(posedge sys_clk) begin
		if (conf_wr_en) begin
			mem[conf_addr] <= conf_wr_data;
		end
	end
	// read is combinational, as the port expects
	assign conf_rd_data = mem[conf_addr];
endmodule : sipp_conf_store
`default_nettype wire

// >>> dv/sipp_assertions.sv
// concurrent checks on the request and alignment ports
`timescale 1ns/1ps
`default_nettype none
module sipp_assertions
	import sipp_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       reset,
	input wire logic       clk_en,
	input wire logic       req_valid,
	input wire logic [6:0] req_cfg_num,
	input wire logic       req_write,
	input wire logic       raw_valid,
	input wire logic       req_busy,
	input wire logic       req_done,
	input wire logic       req_refused,
	input wire logic [4:0] sel_sensor_id,
	input wire logic       sel_wakeup,
	input wire logic       sel_config,
	input wire logic       conf_wr_en,
	input wire logic       aligned_valid
);
	logic take;
	logic bad;
	assign take = clk_en && req_valid && !req_busy && !req_done;
	// id zero or a write to an information entry
	assign bad = req_cfg_num[4:0] == 5'h00 || (req_write && !req_cfg_num[6]);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_refuse_with_done:
	assert property (req_refused |-> req_done) else $error("lone refusal");
	a_zero_id:
	assert property (take && req_cfg_num[4:0] == 5'h00 |=> req_refused)
		else $error("id zero accepted");
	a_info_readonly:
	assert property (take && req_write && !req_cfg_num[6] |=> req_refused)
		else $error("info write accepted");
	a_number_decode:
	assert property (take && !bad |=> req_busy && !req_refused
		&& sel_sensor_id == $past(req_cfg_num[4:0])
		&& sel_wakeup == $past(req_cfg_num[5])
		&& sel_config == $past(req_cfg_num[6])) else $error("bad decode");
	a_fill_span:
	assert property ($rose(req_busy) |-> ##[16:17] req_done)
		else $error("record fill length");
	a_conf_write_only:
	assert property (conf_wr_en |-> req_busy && sel_config)
		else $error("stray config write");
	a_align_latency:
	assert property (raw_valid && clk_en |=> aligned_valid)
		else $error("aligned result late");
	a_done_single:
	assert property (req_done |=> !req_done) else $error("long done");
endmodule : sipp_assertions
bind sipp_top sipp_assertions chk (.*);
`default_nettype wire

// >>> dv/sipp_top_test.sv
// self-checking bench for the parameter page block
`timescale 1ns/1ps
`default_nettype none
module sipp_top_test;
	import sipp_pkg::*;
	logic sys_clk, reset, clk_en, req_valid, req_write, wbuf_wr_en;
	logic sensor_present, irq_enabled, raw_valid, req_busy, req_done;
	logic req_refused, sel_wakeup, sel_config, conf_wr_en, aligned_valid;
	logic [6:0] req_cfg_num;
	logic [3:0] wbuf_addr, rbuf_addr, conf_addr;
	logic [7:0] wbuf_data, sensor_driver_tag, drv_revision, supply_current;
	logic [7:0] axis_count, conf_rd_data, conf_wr_data, rbuf_data;
	logic [15:0] dyn_range, sample_rate;
	logic [35:0] coef_flat;
	logic [4:0] sel_sensor_id;
	logic signed [15:0] raw_x, raw_y, raw_z;
	logic signed [21:0] east_north_up_frame_x;
	logic signed [21:0] east_north_up_frame_y;
	logic signed [21:0] east_north_up_frame_z;
	sipp_pwr_type pwr_mode;
	logic [7:0] exp_rec [16];
	logic refused;
	int bad_count = 0;
	int samples_checked = 0;
	sipp_top dut (.*);
	sipp_conf_store cs (.*);
	task automatic summarize();
		if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		samples_checked++;
		if (seen !== want) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	// bounded wait: a hang counts as a mismatch
	task automatic request(input logic [6:0] num, input logic wr);
		int n;
		@(posedge sys_clk) #1;
		{req_cfg_num, req_write, req_valid} = {num, wr, 1'b1};
		@(posedge sys_clk) #1;
		req_valid = 1'b0;
		for (n = 0; n < 40 && req_done !== 1'b1; n++) @(posedge sys_clk) #1;
		refused = req_refused;
		if (n == 40) begin
			bad_count++;
			summarize();
		end
	endtask : request
	// read buffer data lands two edges after its address
	task automatic check_rec(input int first);
		for (int i = first; i < 16; i++) begin
			@(posedge sys_clk) #1;
			rbuf_addr = 4'(i);
			@(posedge sys_clk);
			@(posedge sys_clk) #1;
			check(rbuf_data, exp_rec[i]);
		end
	endtask : check_rec
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		{reset, clk_en, sensor_present, irq_enabled} = 4'hf;
		{req_valid, req_write, wbuf_wr_en, raw_valid, wbuf_addr, rbuf_addr,
			req_cfg_num, wbuf_data, raw_x, raw_y, raw_z} = '0;
		{supply_current, dyn_range, sample_rate, axis_count} = 48'h17_1234_c350_03;
		{sensor_driver_tag, drv_revision} = 16'h5a3c;
		pwr_mode = PWR_ABSENT;
		coef_flat = 36'hf_000f_0001;
		repeat (16) @(posedge sys_clk);
		#1 reset = 1'b0;
		// every power mode; mode 0 doubles as the absent sensor
		for (int m = 0; m < 8; m++) begin
			automatic int num = m * 8 + 3;
			pwr_mode = sipp_pwr_type'(m);
			sensor_present = m != 0;
			irq_enabled = m[0];
			sensor_driver_tag = 8'(m * 16 + 5);
			exp_rec = '{8'(num - 32), sensor_driver_tag, 8'h3c, 8'h17, 8'h34,
				8'h12, {m[2:0], 4'h0, m[0]}, 8'h00, 8'h50, 8'hc3, 8'h03,
				8'h01, 8'h00, 8'h0f, 8'h00, 8'h0f};
			if (m == 0) exp_rec = '{default: 8'h00};
			request(7'(num), 1'b0);
			check(refused, 1'b0);
			check_rec(0);
		end
		// reserved numbers, then a write to an information entry
		for (int k = 0; k < 5; k++) begin
			request(k < 4 ? 7'(k * 32) : 7'h28, k == 4);
			check(refused, 1'b1);
		end
		for (int i = 0; i < 16; i++) begin
			@(posedge sys_clk) #1;
			{wbuf_wr_en, wbuf_addr, wbuf_data} = {1'b1, 4'(i), 8'(8'ha0 + i)};
		end
		@(posedge sys_clk) #1;
		wbuf_wr_en = 1'b0;
		request(7'h41, 1'b1);
		check(refused, 1'b0);
		for (int i = 0; i < 16; i++) check(cs.mem[i], 8'(8'ha0 + i));
		request(7'h61, 1'b0);
		check({sel_wakeup, sel_config, sel_sensor_id}, 7'h61);
		for (int i = 0; i < 16; i++) exp_rec[i] = 8'(8'ha0 + i);
		check_rec(0);
		coef_flat = 36'hc_54de_f321;
		@(posedge sys_clk) #1;
		{raw_x, raw_y, raw_z, raw_valid} = {16'sd100, -16'sd7, 16'sd300, 1'b1};
		@(posedge sys_clk) #1;
		raw_valid = 1'b0;
		check(aligned_valid, 1'b1);
		check(east_north_up_frame_x, 22'sd1307);
		check(east_north_up_frame_y, 22'sd1714);
		check(east_north_up_frame_z, -22'sd879);
		// clock enable low must freeze the aligned result
		clk_en = 1'b0;
		{raw_x, raw_valid} = {16'sd1, 1'b1};
		@(posedge sys_clk) #1;
		check(east_north_up_frame_x, 22'sd1307);
		check(aligned_valid, 1'b1);
		raw_valid = 1'b0;
		clk_en = 1'b1;
		@(posedge sys_clk) #1;
		check(aligned_valid, 1'b0);
		summarize();
	end
endmodule : sipp_top_test
`default_nettype wire
